// >>> rtl/rsc_regs.v
// Status and configuration registers of a dual repeater, reached over I2C.
// Assumes event, pin and bus inputs are asynchronous; enables and fuse data
// come from logic on the same clock.
`timescale 1ns/10ps
`include "rsc_consts.vh"

module rsc_regs #(
    parameter [6:0] DEV_ADDR = 7'h2c,
    parameter [7:0] REV_CODE = 8'h5a  // Arbitrary value
) (
    input  wire       clock,
    input  wire       nrst,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire       gpio1_pin,
    input  wire       gpio0_pin,
    input  wire       wake_evt_port1,
    input  wire       wake_evt_port0,
    input  wire       detach_evt_port1,
    input  wire       detach_evt_port0,
    input  wire       attach_evt_port1,
    input  wire       attach_evt_port0,
    input  wire       overvoltage_port1,
    input  wire       overvoltage_port0,
    input  wire       connected_port1,
    input  wire       connected_port0,
    input  wire       fuse_valid,
    input  wire [7:0] fuse_rx_tuning,
    input  wire [7:0] irq_enable_first,
    input  wire [3:0] irq_enable_second,
    output wire [2:0] ehs_squelch_level_port1,
    output wire [3:0] rx_equalizer_port1,
    output wire       repeater1_off,
    output wire       repeater0_off,
    output wire       soft_reset_pulse,
    output wire       int_out,
    output wire       int_oe
);

    // ----------------------------------------
    // Bus engine states
    // ----------------------------------------
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_ADDR = 3'd1;
    localparam [2:0] S_AACK = 3'd2;
    localparam [2:0] S_RX   = 3'd3;
    localparam [2:0] S_RACK = 3'd4;
    localparam [2:0] S_TX   = 3'd5;
    localparam [2:0] S_TACK = 3'd6;

    reg  [2:0]  st_reg;
    reg  [7:0]  sh_reg;
    reg  [3:0]  cnt_reg;
    reg  [7:0]  ptr_reg;
    reg         rw_reg;
    reg         first_reg;
    reg         nak_reg;
    reg         sda_drv_reg;
    reg         wr_en_reg;
    reg  [7:0]  wr_addr_reg;
    reg  [7:0]  wr_data_reg;
    reg  [1:0]  scl_s_reg;
    reg  [1:0]  sda_s_reg;
    reg         scl_d_reg;
    reg         sda_d_reg;
    reg  [11:0] pin_s1_reg;
    reg  [11:0] pin_s2_reg;
    reg  [11:0] pin_d_reg;
    reg  [7:0]  rx_tune_reg;
    reg  [7:0]  global_reg;
    reg         soft_rst_reg;
    reg         off1_reg;
    reg         off0_reg;
    reg         int_out_reg;
    reg         int_oe_reg;
    wire        rst_regs;
    wire        scl_rise;
    wire        scl_fall;
    wire        bus_start;
    wire        bus_stop;
    wire [11:0] rise;
    wire [11:0] fall;
    wire [7:0]  set_first;
    wire [3:0]  set_second;
    wire [7:0]  flags_first;
    wire [3:0]  flags_second;
    wire        wr_first;
    wire        wr_second;
    wire        irq_active;

    // Soft reset spares the bus engine so the causing write still gets its ACK
    assign rst_regs = ~nrst | soft_rst_reg;

    // Read decode, shared by first and later bytes
    function [7:0] read_mux;
        input [7:0] addr;
        begin
            case (addr)
                `RSC_OFF_RX_TUNE:  read_mux = rx_tune_reg;
                `RSC_OFF_FLAGS1:   read_mux = flags_first;
                `RSC_OFF_FLAGS2:   read_mux = {4'h0, flags_second};
                `RSC_OFF_REVISION: read_mux = REV_CODE;
                `RSC_OFF_GLOBAL:   read_mux = global_reg;
                default:           read_mux = 8'h00;
            endcase
        end
    endfunction

    // Bus line synchronisers
    always @(posedge clock) begin
        if (!nrst) begin
            scl_s_reg <= 2'h3;
            sda_s_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_s_reg <= {scl_s_reg[0], scl_in};
            sda_s_reg <= {sda_s_reg[0], sda_in};
            scl_d_reg <= scl_s_reg[1];
            sda_d_reg <= sda_s_reg[1];
        end
    end

    assign scl_rise  = scl_s_reg[1] & ~scl_d_reg;
    assign scl_fall  = ~scl_s_reg[1] & scl_d_reg;
    assign bus_start = scl_s_reg[1] & scl_d_reg & sda_d_reg & ~sda_s_reg[1];
    assign bus_stop  = scl_s_reg[1] & scl_d_reg & ~sda_d_reg & sda_s_reg[1];

    // ----------------------------------------
    // Bus engine: first data byte sets the pointer, later bytes auto-increment
    // ----------------------------------------
    always @(posedge clock) begin
        if (!nrst) begin
            st_reg      <= S_IDLE;
            sh_reg      <= 8'h00;
            cnt_reg     <= 4'h0;
            ptr_reg     <= 8'h00;
            rw_reg      <= 1'b0;
            first_reg   <= 1'b0;
            nak_reg     <= 1'b0;
            sda_drv_reg <= 1'b0;
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_en_reg <= 1'b0;
            if (bus_start) begin
                st_reg      <= S_ADDR;
                cnt_reg     <= 4'h0;
                sda_drv_reg <= 1'b0;
            end else if (bus_stop) begin
                st_reg      <= S_IDLE;
                sda_drv_reg <= 1'b0;
            end else if (scl_rise) begin
                case (st_reg)
                    S_ADDR, S_RX: begin
                        sh_reg  <= {sh_reg[6:0], sda_s_reg[1]};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    S_TX: begin
                        sh_reg  <= {sh_reg[6:0], 1'b0};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    S_TACK: begin
                        nak_reg <= sda_s_reg[1];
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (st_reg)
                    S_ADDR: begin
                        if (cnt_reg == 4'h8) begin
                            if (sh_reg[7:1] == DEV_ADDR) begin
                                rw_reg      <= sh_reg[0];
                                sda_drv_reg <= 1'b1;
                                st_reg      <= S_AACK;
                            end else begin
                                st_reg <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            sh_reg      <= read_mux(ptr_reg);
                            sda_drv_reg <= ~|(read_mux(ptr_reg) & 8'h80);
                            st_reg      <= S_TX;
                        end else begin
                            sda_drv_reg <= 1'b0;
                            first_reg   <= 1'b1;
                            st_reg      <= S_RX;
                        end
                    end
                    S_RX: begin
                        if (cnt_reg == 4'h8) begin
                            sda_drv_reg <= 1'b1;
                            st_reg      <= S_RACK;
                            if (first_reg) begin
                                ptr_reg <= sh_reg;
                            end else begin
                                wr_en_reg   <= 1'b1;
                                wr_addr_reg <= ptr_reg;
                                wr_data_reg <= sh_reg;
                            end
                        end
                    end
                    S_RACK: begin
                        sda_drv_reg <= 1'b0;
                        cnt_reg     <= 4'h0;
                        first_reg   <= 1'b0;
                        st_reg      <= S_RX;
                        if (!first_reg) begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                    end
                    S_TX: begin
                        if (cnt_reg == 4'h8) begin
                            sda_drv_reg <= 1'b0;
                            st_reg      <= S_TACK;
                        end else begin
                            sda_drv_reg <= ~sh_reg[7];
                        end
                    end
                    S_TACK: begin
                        cnt_reg <= 4'h0;
                        if (nak_reg) begin
                            st_reg <= S_IDLE;
                        end else begin
                            ptr_reg     <= ptr_reg + 8'h01;
                            sh_reg      <= read_mux(ptr_reg + 8'h01);
                            sda_drv_reg <= ~|(read_mux(ptr_reg + 8'h01) & 8'h80);
                            st_reg      <= S_TX;
                        end
                    end
                    default: begin
                        sda_drv_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain data line: only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_drv_reg;

    // ----------------------------------------
    // Event synchronisers, edge detect and status flags
    // ----------------------------------------
    // A pin already high at reset release reads as a rising edge once.
    always @(posedge clock) begin
        if (!nrst) begin
            pin_s1_reg <= 12'h000;
            pin_s2_reg <= 12'h000;
            pin_d_reg  <= 12'h000;
        end else begin
            pin_s1_reg <= {gpio1_pin, gpio0_pin, wake_evt_port1, detach_evt_port1,
                           wake_evt_port0, detach_evt_port0, attach_evt_port1,
                           attach_evt_port0, overvoltage_port1, overvoltage_port0,
                           connected_port1, connected_port0};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    assign rise = pin_s2_reg & ~pin_d_reg;
    assign fall = ~pin_s2_reg & pin_d_reg;

    assign set_first  = {rise[11], fall[11], rise[10], fall[10],
                         rise[9], rise[8],
                         rise[7], rise[6]};
    assign set_second = {rise[5], rise[4], rise[3], rise[2]};

    assign wr_first  = wr_en_reg & (wr_addr_reg == `RSC_OFF_FLAGS1);
    assign wr_second = wr_en_reg & (wr_addr_reg == `RSC_OFF_FLAGS2);

    rsc_sticky_flags #(.W(8)) u_flags_first (
        .clock    (clock),
        .rst      (rst_regs),
        .set_evt  (set_first),
        .clr_wr   (wr_first),
        .clr_mask (wr_data_reg),
        .flags    (flags_first)
    );

    rsc_sticky_flags #(.W(`RSC_F2_WIDTH)) u_flags_second (
        .clock    (clock),
        .rst      (rst_regs),
        .set_evt  (set_second),
        .clr_wr   (wr_second),
        .clr_mask (wr_data_reg[3:0]),
        .flags    (flags_second)
    );

    // ----------------------------------------
    // Tuning, global setup, soft reset and deferred repeater disable
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst_regs) begin
            rx_tune_reg <= fuse_valid ? fuse_rx_tuning : `RSC_RST_RX_TUNE;
        end else if (wr_en_reg && wr_addr_reg == `RSC_OFF_RX_TUNE) begin
            rx_tune_reg <= wr_data_reg;
        end
    end

    assign ehs_squelch_level_port1 = rx_tune_reg[`RSC_SQ_HI:`RSC_SQ_LO];
    assign rx_equalizer_port1      = rx_tune_reg[`RSC_EQ_HI:`RSC_EQ_LO];

    always @(posedge clock) begin
        if (rst_regs) begin
            global_reg <= `RSC_RST_GLOBAL;
        end else if (wr_en_reg && wr_addr_reg == `RSC_OFF_GLOBAL) begin
            global_reg <= wr_data_reg & `RSC_GL_STORE_MASK;
        end
    end

    // One-cycle pulse; held only by the pin reset so it cannot clear itself early
    always @(posedge clock) begin
        if (!nrst) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_en_reg & (wr_addr_reg == `RSC_OFF_GLOBAL)
                            & wr_data_reg[`RSC_GL_SOFT_RST];
        end
    end

    assign soft_reset_pulse = soft_rst_reg;

    always @(posedge clock) begin
        if (rst_regs) begin
            off1_reg <= 1'b0;
            off0_reg <= 1'b0;
        end else begin
            off1_reg <= global_reg[`RSC_GL_OFF1] & (off1_reg | ~pin_s2_reg[1]);
            off0_reg <= global_reg[`RSC_GL_OFF0] & (off0_reg | ~pin_s2_reg[0]);
        end
    end

    assign repeater1_off = off1_reg;
    assign repeater0_off = off0_reg;

    // ----------------------------------------
    // Interrupt pin
    // ----------------------------------------
    assign irq_active = |(flags_first & irq_enable_first)
                      | |(flags_second & irq_enable_second);

    always @(posedge clock) begin
        if (rst_regs) begin
            int_out_reg <= 1'b0;
            int_oe_reg  <= 1'b0;
        end else if (global_reg[`RSC_GL_PUSHPULL]) begin
            int_out_reg <= irq_active ^ global_reg[`RSC_GL_ACT_LOW];
            int_oe_reg  <= 1'b1;
        end else begin
            int_out_reg <= 1'b0;
            int_oe_reg  <= irq_active;
        end
    end

    assign int_out = int_out_reg;
    assign int_oe  = int_oe_reg;

endmodule

// >>> rtl/rsc_consts.vh
// Constants of the repeater status and configuration register group.
// Assumes a single 250 MHz clock domain and a synchronous active-low reset.

`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSC_OFF_RX_TUNE   8'h79
`define RSC_OFF_FLAGS1    8'ha3
`define RSC_OFF_FLAGS2    8'ha4
`define RSC_OFF_REVISION  8'hb0
`define RSC_OFF_GLOBAL    8'hb2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSC_RST_RX_TUNE   8'h62
`define RSC_RST_FLAGS1    8'h00
`define RSC_RST_FLAGS2    4'h0
`define RSC_RST_GLOBAL    8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSC_SQ_HI         6
`define RSC_SQ_LO         4
`define RSC_EQ_HI         3
`define RSC_EQ_LO         0
`define RSC_GL_SOFT_RST   7
`define RSC_GL_OFF1       6
`define RSC_GL_OFF0       5
`define RSC_GL_PUSHPULL   4
`define RSC_GL_ACT_LOW    3
`define RSC_GL_STORE_MASK 8'h7c
`define RSC_F2_WIDTH      4

`endif

// >>> rtl/rsc_sticky_flags.v
// Bank of sticky event flags with write-one-to-clear.
// Assumes set pulses and clear writes come from the same clock domain.
`timescale 1ns/10ps

module rsc_sticky_flags #(
    parameter W = 8
) (
    input  wire         clock,
    input  wire         rst,
    input  wire [W-1:0] set_evt,
    input  wire         clr_wr,
    input  wire [W-1:0] clr_mask,
    output wire [W-1:0] flags
);

    reg  [W-1:0] flags_reg;
    wire [W-1:0] flags_next;

    // ----------------------------------------
    // Set wins over a clear in the same cycle
    // ----------------------------------------
    assign flags_next = (flags_reg & ~(clr_wr ? clr_mask : {W{1'b0}})) | set_evt;

    always @(posedge clock) begin
        if (rst) begin
            flags_reg <= {W{1'b0}};
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule

// >>> sim/rsc_regs_chk.sv
// Assertions on the pins of the repeater register group.
// Assumes the bench holds enables steady around each event pulse.
`timescale 1ns/10ps

module rsc_regs_chk (
    input wire       clock,
    input wire       nrst,
    input wire       scl_in,
    input wire       sda_oe,
    input wire       gpio1_pin,
    input wire       wake_evt_port0,
    input wire       attach_evt_port1,
    input wire       overvoltage_port0,
    input wire       connected_port1,
    input wire       connected_port0,
    input wire       fuse_valid,
    input wire [7:0] fuse_rx_tuning,
    input wire [7:0] irq_enable_first,
    input wire [3:0] irq_enable_second,
    input wire [2:0] ehs_squelch_level_port1,
    input wire [3:0] rx_equalizer_port1,
    input wire       repeater1_off,
    input wire       repeater0_off,
    input wire       soft_reset_pulse,
    input wire       int_out,
    input wire       int_oe
);
    wire [6:0] fuse_low = fuse_rx_tuning[6:0];

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // ----
    // Checks
    // ----
    // SDA may only move while SCL is low, or a false start or stop appears
    AST_SDA_SCL: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved while scl high");
    AST_INT_OD: assert property (!int_oe |-> !int_out)
        else $error("released interrupt pin driven high");
    AST_SRST_ONE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");
    AST_SRST_TUNE: assert property (soft_reset_pulse |=>
        {ehs_squelch_level_port1, rx_equalizer_port1} ==
        ($past(fuse_valid) ? $past(fuse_low) : 7'h62))
        else $error("tuning not reloaded by soft reset");
    AST_SRST_OFF: assert property (soft_reset_pulse |=> !repeater1_off && !repeater0_off)
        else $error("repeater left off after soft reset");
    AST_SRST_INT: assert property (soft_reset_pulse |-> ##2 !int_oe)
        else $error("interrupt pin active after soft reset");
    AST_OFF1: assert property ($rose(repeater1_off) |-> !$past(connected_port1, 3))
        else $error("repeater 1 off while connected");
    AST_OFF0: assert property ($rose(repeater0_off) |-> !$past(connected_port0, 3))
        else $error("repeater 0 off while connected");
    AST_EVT_WAKE0: assert property ($rose(wake_evt_port0) && irq_enable_first[1]
        |-> ##[3:7] int_oe)
        else $error("wake event gave no interrupt");
    AST_EVT_GPIO1: assert property ($fell(gpio1_pin) && irq_enable_first[6]
        |-> ##[3:7] int_oe)
        else $error("pin fall gave no interrupt");
    AST_EVT_ATT1: assert property ($rose(attach_evt_port1) && irq_enable_second[3]
        |-> ##[3:7] int_oe)
        else $error("attach event gave no interrupt");
    AST_EVT_OVP0: assert property ($rose(overvoltage_port0) && irq_enable_second[0]
        |-> ##[3:7] int_oe)
        else $error("overvoltage gave no interrupt");

    cover property (soft_reset_pulse);
    cover property ($rose(repeater1_off));
    cover property ($rose(int_oe) && !int_out);
endmodule

bind rsc_regs rsc_regs_chk chk (
    .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_oe(sda_oe), .gpio1_pin(gpio1_pin),
    .wake_evt_port0(wake_evt_port0), .attach_evt_port1(attach_evt_port1),
    .overvoltage_port0(overvoltage_port0), .connected_port1(connected_port1),
    .connected_port0(connected_port0), .fuse_valid(fuse_valid),
    .fuse_rx_tuning(fuse_rx_tuning), .irq_enable_first(irq_enable_first),
    .irq_enable_second(irq_enable_second), .ehs_squelch_level_port1(ehs_squelch_level_port1),
    .rx_equalizer_port1(rx_equalizer_port1), .repeater1_off(repeater1_off),
    .repeater0_off(repeater0_off), .soft_reset_pulse(soft_reset_pulse),
    .int_out(int_out), .int_oe(int_oe));

// >>> sim/rsc_host.sv
// I2C controller model reaching the register group over SCL and SDA.
// Assumes the bench resolves SDA from both open-drain drivers with a pull-up.
`timescale 1ns/10ps

module rsc_host #(
    parameter       Q   = 8,
    parameter [6:0] DEV = 7'h2c
) (
    input  wire clock,
    input  wire sda_line,
    output reg  scl_o,
    output reg  sda_low
);
    reg acked;
    reg s;

    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
        acked = 1'b1;
    end

    // ----
    // Bus cycles
    // ----
    // SDA only moves while SCL is low, so no false start or stop
    task slot(input lo, output smp);
        begin
            sda_low = lo;
            repeat (Q) @(negedge clock);
            scl_o = 1'b1;
            repeat (Q) @(negedge clock);
            smp = sda_line;
            scl_o = 1'b0;
            repeat (Q) @(negedge clock);
        end
    endtask

    // Also serves as repeated start
    task start_c;
        begin
            sda_low = 1'b0;
            repeat (Q) @(negedge clock);
            scl_o = 1'b1;
            repeat (Q) @(negedge clock);
            sda_low = 1'b1;
            repeat (Q) @(negedge clock);
            scl_o = 1'b0;
            repeat (Q) @(negedge clock);
        end
    endtask

    task stop_c;
        begin
            sda_low = 1'b1;
            repeat (Q) @(negedge clock);
            scl_o = 1'b1;
            repeat (Q) @(negedge clock);
            sda_low = 1'b0;
            repeat (Q) @(negedge clock);
        end
    endtask

    task w8(input [7:0] b);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                slot(!b[i], s);
            end
            slot(1'b0, s);
            if (s !== 1'b0) begin
                acked = 1'b0;
            end
        end
    endtask

    task wr(input [6:0] dev, input [7:0] a, input [7:0] d);
        begin
            acked = 1'b1;
            start_c;
            w8({dev, 1'b0});
            w8(a);
            w8(d);
            stop_c;
        end
    endtask

    // Two bytes: the first is acknowledged, the last refused to end the read
    task rd(input [7:0] a, output [15:0] d);
        integer i;
        begin
            acked = 1'b1;
            start_c;
            w8({DEV, 1'b0});
            w8(a);
            start_c;
            w8({DEV, 1'b1});
            for (i = 15; i >= 0; i = i - 1) begin
                slot(1'b0, d[i]);
                if (i == 8) slot(1'b1, s);
            end
            slot(1'b0, s);
            stop_c;
        end
    endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the repeater register group with a behavioural model.
// Assumes the host model drives I2C; the bench drives events and enables.
`timescale 1ns/10ps

module testbench;
    localparam [7:0] REV = 8'hc5;  // Arbitrary value
    reg        clock;
    reg        nrst;
    reg  [9:0] ev;
    reg        con1;
    reg        con0;
    reg        fuse_valid;
    reg  [7:0] fuse;
    reg  [7:0] en1;
    reg  [3:0] en2;
    reg  [7:0] m_tune;
    reg  [7:0] m_f1;
    reg  [3:0] m_f2;
    reg  [7:0] m_gl;
    reg [15:0] got;
    reg [31:0] r;
    integer    seed;
    integer    fails;
    integer    tests_run;
    integer    i;
    logic [7:0] offs[$] = '{8'h79, 8'ha3, 8'ha4, 8'hb0, 8'hb2, 8'h55};
    wire       scl;
    wire       sda_low;
    wire       sda_oe;
    wire       sda_o;
    wire       sda_line;
    wire [2:0] sq;
    wire [3:0] eq;
    wire       off1;
    wire       off0;
    wire       int_out;
    wire       int_oe;

    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    rsc_regs #(.REV_CODE(REV)) dut (
        .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
        .sda_oe(sda_oe), .gpio1_pin(ev[5]), .gpio0_pin(ev[4]), .wake_evt_port1(ev[3]),
        .wake_evt_port0(ev[1]), .detach_evt_port1(ev[2]), .detach_evt_port0(ev[0]),
        .attach_evt_port1(ev[9]), .attach_evt_port0(ev[8]), .overvoltage_port1(ev[7]),
        .overvoltage_port0(ev[6]), .connected_port1(con1), .connected_port0(con0),
        .fuse_valid(fuse_valid), .fuse_rx_tuning(fuse), .irq_enable_first(en1),
        .irq_enable_second(en2), .ehs_squelch_level_port1(sq), .rx_equalizer_port1(eq),
        .repeater1_off(off1), .repeater0_off(off0), .soft_reset_pulse(),
        .int_out(int_out), .int_oe(int_oe));

    rsc_host host (.clock(clock), .sda_line(sda_line), .scl_o(scl), .sda_low(sda_low));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ----
    // Model and checks
    // ----
    task check(input string name, input [7:0] exp, input [7:0] seen);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    function [7:0] mread(input [7:0] a);
        case (a)
            8'h79: mread = m_tune;
            8'ha3: mread = m_f1;
            8'ha4: mread = {4'h0, m_f2};
            8'hb0: mread = REV;
            8'hb2: mread = m_gl;
            default: mread = 8'h00;
        endcase
    endfunction

    task wreg(input [7:0] a, input [7:0] d);
        begin
            host.wr(7'h2c, a, d);
            check("ack", 8'h01, {7'h0, host.acked});
            case (a)
                8'h79: m_tune = d;
                8'ha3: m_f1 = m_f1 & ~d;
                8'ha4: m_f2 = m_f2 & ~d[3:0];
                8'hb2: m_gl = d & 8'h7c;
                default: ;
            endcase
            if (a == 8'hb2 && d[7]) begin
                m_tune = fuse_valid ? fuse : 8'h62;
                m_f1 = 8'h00;
                m_f2 = 4'h0;
                m_gl = 8'h00;
            end
        end
    endtask

    task rchk(input [7:0] a);
        begin
            host.rd(a, got);
            check($sformatf("reg %h", a), mread(a), got[15:8]);
            check($sformatf("reg %h", a + 8'h01), mread(a + 8'h01), got[7:0]);
        end
    endtask

    // Pin waits out the event synchroniser before it is judged
    task ichk;
        reg       act;
        reg [1:0] exp;
        begin
            repeat (8) @(negedge clock);
            act = (|(m_f1 & en1)) || (|(m_f2 & en2));
            exp = m_gl[4] ? {1'b1, act ^ m_gl[3]} : {act, 1'b0};
            check("int pin", {6'h0, exp}, {6'h0, int_oe, int_out});
        end
    endtask

    task pulse(input integer k);
        begin
            ev[k] = 1'b1;
            repeat (8) @(negedge clock);
            ev[k] = 1'b0;
            repeat (8) @(negedge clock);
            if (k < 4) {m_f2, m_f1} = {m_f2, m_f1} | (12'h001 << k);
            else if (k == 4) m_f1 = m_f1 | 8'h30;
            else if (k == 5) m_f1 = m_f1 | 8'hc0;
            else {m_f2, m_f1} = {m_f2, m_f1} | (12'h100 << (k - 6));
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    initial begin
        #360000;
        fails = fails + 1;
        finish_test;
    end

    initial begin
        {nrst, con1, con0, fuse_valid, ev, en1, en2, fuse} = 0;
        {m_f1, m_f2, m_gl} = 0;
        m_tune = 8'h62;
        seed = 7;
        fails = 0;
        tests_run = 0;
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        repeat (8) @(negedge clock);
        check("squelch", 8'h06, {5'h0, sq});
        check("equalizer", 8'h02, {4'h0, eq});
        ichk;
        wreg(8'hb0, 8'hff);
        wreg(8'h55, 8'hff);
        foreach (offs[j]) rchk(offs[j]);
        $display("test reset and read-only done");
        for (i = 0; i < 4; i = i + 1) begin
            r = $random(seed);
            wreg(8'h79, r[7:0]);
            rchk(8'h79);
            check("squelch", {5'h0, m_tune[6:4]}, {5'h0, sq});
            check("equalizer", {4'h0, m_tune[3:0]}, {4'h0, eq});
        end
        $display("test tuning done");
        en1 = 8'hff;
        en2 = 4'hf;
        for (i = 0; i < 10; i = i + 1) pulse(i);
        rchk(8'ha3);
        rchk(8'ha4);
        wreg(8'ha3, 8'h00);
        wreg(8'ha4, 8'hf0);
        rchk(8'ha3);
        rchk(8'ha4);
        for (i = 0; i < 3; i = i + 1) begin
            r = $random(seed);
            wreg(8'ha3, r[7:0]);
            wreg(8'ha4, r[15:8]);
            rchk(8'ha3);
            rchk(8'ha4);
            ichk;
        end
        $display("test event flags done");
        for (i = 0; i < 4; i = i + 1) begin
            wreg(8'hb2, {3'h0, i[1:0], 3'h0});
            wreg(8'ha3, 8'hff);
            wreg(8'ha4, 8'h0f);
            r = $random(seed);
            en1 = r[7:0] | 8'h02;
            en2 = r[11:8];
            ichk;
            pulse(1);
            ichk;
            en1 = en1 & 8'hfd;
            ichk;
        end
        $display("test interrupt pin done");
        con1 = 1'b1;
        wreg(8'hb2, 8'h60);
        check("off1", 8'h00, {7'h0, off1});
        check("off0", 8'h01, {7'h0, off0});
        con1 = 1'b0;
        repeat (8) @(negedge clock);
        check("off1", 8'h01, {7'h0, off1});
        rchk(8'hb2);
        $display("test repeater off done");
        r = $random(seed);
        fuse = r[7:0];
        fuse_valid = 1'b1;
        wreg(8'hb2, 8'h80);
        foreach (offs[j]) rchk(offs[j]);
        check("off", 8'h00, {6'h0, off1, off0});
        host.wr(7'h2d, 8'h79, ~fuse);
        rchk(8'h79);
        $display("test soft reset done");
        finish_test;
    end
endmodule
